// ---- rinit_top.sv ----
// TAP-driven RAM initialisation interface: capture, buffering and RAM write sequencing
// Operation
// - Shift register moves only during shift strobe
// - Instruction value governs counters and block selects
// - Instruction value compared against start opcode constantly
// - Addresses and write enables only while matched
// - Write clock, pipeline, address follow update strobe
// - Update edge presents data word and address
// - Write clock is inverse of internal setup strobe
// - Falling-edge RAMs take internal setup strobe uninverted
// - Ring counter advances after each block completes
`include "rinit_consts.svh"
`timescale 1ns/1ps
module rinit_top
  import rinit_pkg::*;
#(
  parameter int DATA_W = `RINIT_DATA_W,
  parameter int ADDR_W = `RINIT_ADDR_W,
  parameter int IR_W = `RINIT_IR_W,
  parameter int NUM_BLOCKS = `RINIT_NUM_BLOCKS,
  parameter int FIFO_DEPTH = `RINIT_FIFO_DEPTH,
  parameter logic [IR_W-1:0] START_OPCODE = `RINIT_START_OPCODE,
  parameter bit WCLK_FALLING = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // TAP macro side (asynchronous)
  input wire logic tapClk,
  input wire logic tapTdi,
  input wire logic dr_shift_strobe,
  input wire logic dr_update_strobe,
  input wire logic [IR_W-1:0] user_instruction_value,
  // Back-pressure toward the JTAG driver
  output logic loadReady_q,
  // RAM write ports
  output logic [ADDR_W-1:0] ramAddr_q,
  output logic [DATA_W-1:0] ramData_q,
  output logic [NUM_BLOCKS-1:0] ramWrEn_q,
  output logic ramWrClk_q
);
  localparam int SETUP_CYC = `RINIT_SETUP_CYC;
  localparam int CW = $clog2(SETUP_CYC + 1);
  // ****************************************
  // Synchronisers
  // ****************************************
  logic [3+IR_W:0] syncA_q, syncB_q;
  logic tckPrev_q, updPrev_q;
  logic tckS, tdiS, shS, updS;
  logic [IR_W-1:0] irS;

  always_ff @(posedge ref_clk) begin
    syncA_q <= {tapClk, tapTdi, dr_shift_strobe, dr_update_strobe, user_instruction_value};
    syncB_q <= syncA_q;
  end
  assign {tckS, tdiS, shS, updS, irS} = syncB_q;

  // ****************************************
  // Shift register and opcode compare
  // ****************************************
  // Width equals RAM word so one update pass carries one word
  logic [DATA_W-1:0] shReg_q, shReg_d;
  logic match_q, match_d, matchPrev_q;
  logic tckRise, updRise, matchRise;

  assign tckRise = tckS && !tckPrev_q;
  assign updRise = updS && !updPrev_q;
  assign matchRise = match_q && !matchPrev_q;

  always_comb begin
    shReg_d = shReg_q;
    if (tckRise && shS) begin
      shReg_d = {tdiS, shReg_q[DATA_W-1:1]};
    end
    match_d = (irS == START_OPCODE);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shReg_q <= '0;
      match_q <= 1'b0;
      matchPrev_q <= 1'b0;
      tckPrev_q <= 1'b0;
      updPrev_q <= 1'b0;
    end else begin
      shReg_q <= shReg_d;
      match_q <= match_d;
      matchPrev_q <= match_q;
      tckPrev_q <= tckS;
      updPrev_q <= updS;
    end
  end

  // ****************************************
  // Word buffer
  // ****************************************
  logic fifoInReady, fifoOutValid, fifoPop;
  logic [DATA_W-1:0] fifoOut;

  rinit_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(updRise),
    .inReady(fifoInReady),
    .inData(shReg_q),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  // ****************************************
  // RAM write sequencer
  // ****************************************
  // Internal strobe is held high for SETUP_CYC cycles in our domain after each word popped while matched so
  // data and address settle before the write clock edge
  rinit_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] data_d;
  logic [NUM_BLOCKS-1:0] ring_q, ring_d, wrEn_d;
  logic strobe_q, strobe_d, wrClk_d;
  // A restart that lands mid-write is held until idle, else it would be lost
  logic restartPend_q, restartPend_d;
  logic lastAddr;

  assign lastAddr = (ramAddr_q == {ADDR_W{1'b1}});
  // Words arriving while not matched are drained and dropped
  assign fifoPop = fifoOutValid && (state_q == RINIT_IDLE) && !matchRise && !restartPend_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = ramAddr_q;
    data_d = ramData_q;
    ring_d = ring_q;
    strobe_d = strobe_q;
    wrEn_d = ramWrEn_q;
    restartPend_d = restartPend_q || matchRise;
    case (state_q)
      RINIT_IDLE: begin
        if (matchRise || restartPend_q) begin
          restartPend_d = 1'b0;
          addr_d = '0;
          ring_d = {{(NUM_BLOCKS-1){1'b0}}, 1'b1};
        end else if (fifoPop && match_q) begin
          data_d = fifoOut;
          strobe_d = 1'b1;
          wrEn_d = ring_q;
          cnt_d = CW'(SETUP_CYC);
          state_d = RINIT_SETUP;
        end
      end
      RINIT_SETUP: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == CW'(1)) begin
          strobe_d = 1'b0;
          state_d = RINIT_WRITE;
        end
      end
      RINIT_WRITE: begin
        wrEn_d = '0;
        addr_d = ramAddr_q + 1'b1;
        if (lastAddr) begin
          ring_d = {ring_q[NUM_BLOCKS-2:0], ring_q[NUM_BLOCKS-1]};
        end
        state_d = RINIT_IDLE;
      end
      default: state_d = RINIT_IDLE;
    endcase
    wrClk_d = WCLK_FALLING ? strobe_d : !strobe_d;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= RINIT_IDLE;
      cnt_q <= '0;
      ramAddr_q <= '0;
      ramData_q <= '0;
      ring_q <= {{(NUM_BLOCKS-1){1'b0}}, 1'b1};
      strobe_q <= 1'b0;
      ramWrEn_q <= '0;
      ramWrClk_q <= !WCLK_FALLING;
      loadReady_q <= 1'b0;
      restartPend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ramAddr_q <= addr_d;
      ramData_q <= data_d;
      ring_q <= ring_d;
      strobe_q <= strobe_d;
      ramWrEn_q <= wrEn_d;
      ramWrClk_q <= wrClk_d;
      loadReady_q <= fifoInReady;
      restartPend_q <= restartPend_d;
    end
  end

  // Run length of the setup strobe, so its length is checked without a long repetition
  logic [CW-1:0] strobeRun_q, strobeRun_d;

  always_comb begin
    strobeRun_d = strobe_q ? strobeRun_q + 1'b1 : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobeRun_q <= '0;
    end else begin
      strobeRun_q <= strobeRun_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_shift_hold;
    @(posedge ref_clk) disable iff (rst) !(tckRise && shS) |=> $stable(shReg_q);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift reg moved without strobe");

  property p_match;
    @(posedge ref_clk) disable iff (rst) !$past(rst) |-> match_q == ($past(irS) == START_OPCODE);
  endproperty
  a_match: assert property (p_match) else $error("opcode compare wrong");

  property p_en_needs_match;
    @(posedge ref_clk) disable iff (rst) $rose(|ramWrEn_q) |-> $past(match_q);
  endproperty
  a_en_needs_match: assert property (p_en_needs_match) else $error("write enable without match");

  property p_en_is_ring;
    @(posedge ref_clk) disable iff (rst) (|ramWrEn_q) |-> (ramWrEn_q == ring_q);
  endproperty
  a_en_is_ring: assert property (p_en_is_ring) else $error("enable not selected block");

  property p_wclk_polarity;
    @(posedge ref_clk) disable iff (rst) ramWrClk_q == (WCLK_FALLING ? strobe_q : !strobe_q);
  endproperty
  a_wclk_polarity: assert property (p_wclk_polarity) else $error("write clock polarity wrong");

  property p_setup_len;
    @(posedge ref_clk) disable iff (rst)
      (strobe_q || $fell(strobe_q)) |->
        (strobe_q ? (strobeRun_q < CW'(SETUP_CYC)) : (strobeRun_q == CW'(SETUP_CYC)));
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

  property p_data_stable;
    @(posedge ref_clk) disable iff (rst) strobe_q |=> $stable(ramData_q) && $stable(ramAddr_q);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved during setup");

  property p_addr_step;
    @(posedge ref_clk) disable iff (rst)
      (state_q == RINIT_WRITE) |=> ramAddr_q == $past(ramAddr_q) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not advance");

  property p_ring_step;
    @(posedge ref_clk) disable iff (rst)
      (state_q == RINIT_WRITE) && lastAddr |=> ring_q != $past(ring_q);
  endproperty
  a_ring_step: assert property (p_ring_step) else $error("block select did not advance");

  property p_restart;
    @(posedge ref_clk) disable iff (rst) matchRise && state_q == RINIT_IDLE |=> ramAddr_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("address not restarted");

  c_write: cover property (@(posedge ref_clk) disable iff (rst) $rose(|ramWrEn_q));
  c_wrap: cover property (@(posedge ref_clk) disable iff (rst) state_q == RINIT_WRITE && lastAddr);
  c_full: cover property (@(posedge ref_clk) disable iff (rst) !fifoInReady);
endmodule : rinit_top

// ---- rinit_consts.svh ----
// Constants for the TAP-driven RAM initialisation interface
`ifndef RINIT_CONSTS_SVH
`define RINIT_CONSTS_SVH
// ****************************************
// Widths and defaults
// ****************************************
`define RINIT_DATA_W 8
`define RINIT_ADDR_W 4
`define RINIT_IR_W 8
`define RINIT_NUM_BLOCKS 2
`define RINIT_FIFO_DEPTH 16
`define RINIT_START_OPCODE 8'h5a
// ****************************************
// Timing
// ****************************************
`define RINIT_CLK_MHZ 250
`define RINIT_SETUP_NS 8
// Least time, rounded up, at least one cycle
`define RINIT_SETUP_CYC (((`RINIT_SETUP_NS * `RINIT_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
  ((`RINIT_SETUP_NS * `RINIT_CLK_MHZ + 999) / 1000))
`endif

// ---- rinit_pkg.sv ----
// Types for the TAP-driven RAM initialisation interface
package rinit_pkg;
  typedef enum logic [1:0] {
    RINIT_IDLE,
    RINIT_SETUP,
    RINIT_WRITE
  } rinit_state_t;
endpackage : rinit_pkg

// ---- rinit_fifo.sv ----
// Word FIFO between the TAP capture side and the RAM write side
`timescale 1ns/1ps
module rinit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0] count_q, count_d;
  logic doPush, doPop;

  assign inReady = (count_q != DEPTH[PW:0]);
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (doPush) begin
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (doPop) begin
      rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (doPush && !doPop) begin
      count_d = count_q + 1'b1;
    end else if (doPop && !doPush) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule : rinit_fifo

// ---- rinit_ram_model.sv ----
// RAM blocks that capture a word on each rising write clock
`timescale 1ns/1ps
module rinit_ram_model #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 4,
  parameter int NUM_BLOCKS = 2
) (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic [ADDR_W-1:0] ramAddr_q,
  input wire logic [DATA_W-1:0] ramData_q,
  input wire logic [NUM_BLOCKS-1:0] ramWrEn_q,
  input wire logic ramWrClk_q
);
  logic [DATA_W-1:0] mem [NUM_BLOCKS][2**ADDR_W];
  int nWrites = 0;
  int lastBlk = -1;
  logic clkSeen = 1'b1;
  // Write clock is registered, so sampling it on ref_clk catches every edge
  always @(posedge ref_clk) begin
    if (ramWrClk_q === 1'b1 && clkSeen === 1'b0 && |ramWrEn_q) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        if (ramWrEn_q[b] === 1'b1) begin
          mem[b][ramAddr_q] <= ramData_q;
          lastBlk <= b;
        end
      end
      nWrites <= nWrites + 1;
    end
    clkSeen <= ramWrClk_q;
  end
endmodule : rinit_ram_model

// ---- testbench.sv ----
// Self-checking testbench for the TAP-driven RAM initialisation interface
`include "rinit_consts.svh"
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] OPC = `RINIT_START_OPCODE;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tapClk = 1'b0;
  logic tapTdi = 1'b0;
  logic dr_shift_strobe = 1'b0;
  logic dr_update_strobe = 1'b0;
  logic [`RINIT_IR_W-1:0] user_instruction_value = '0;
  logic loadReady_q;
  logic [`RINIT_ADDR_W-1:0] ramAddr_q;
  logic [`RINIT_DATA_W-1:0] ramData_q;
  logic [`RINIT_NUM_BLOCKS-1:0] ramWrEn_q;
  logic ramWrClk_q;
  logic fallWrClk;
  int n_errors = 0;
  int n_tests = 0;
  int base;
  always #2 ref_clk = ~ref_clk;
  rinit_top rinit_top_i (.ref_clk(ref_clk), .rst(rst), .tapClk(tapClk), .tapTdi(tapTdi),
    .dr_shift_strobe(dr_shift_strobe), .dr_update_strobe(dr_update_strobe),
    .user_instruction_value(user_instruction_value), .loadReady_q(loadReady_q),
    .ramAddr_q(ramAddr_q), .ramData_q(ramData_q), .ramWrEn_q(ramWrEn_q),
    .ramWrClk_q(ramWrClk_q));
  rinit_ram_model rinit_ram_model_i (.ref_clk(ref_clk), .ramAddr_q(ramAddr_q),
    .ramData_q(ramData_q), .ramWrEn_q(ramWrEn_q), .ramWrClk_q(ramWrClk_q));
  // Second copy built for falling-edge RAMs; only its write clock is watched
  if (1) begin : fall_g
    rinit_top #(.WCLK_FALLING(1'b1)) rinit_top_i (.ref_clk(ref_clk), .rst(rst), .tapClk(tapClk),
      .tapTdi(tapTdi), .dr_shift_strobe(dr_shift_strobe), .dr_update_strobe(dr_update_strobe),
      .user_instruction_value(user_instruction_value), .loadReady_q(), .ramAddr_q(),
      .ramData_q(), .ramWrEn_q(), .ramWrClk_q(fallWrClk));
  end
  // ****
  // Helpers
  // ****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Synchronisers need three cycles per level
  task automatic hold();
    repeat (3) @(posedge ref_clk);
  endtask : hold
  task automatic shift_word(input logic [7:0] w, input logic en);
    dr_shift_strobe <= en;
    hold();
    for (int i = 0; i < 8; i++) begin
      tapTdi <= w[i];
      hold();
      tapClk <= 1'b1;
      hold();
      tapClk <= 1'b0;
      hold();
    end
    dr_shift_strobe <= 1'b0;
    hold();
  endtask : shift_word
  task automatic update();
    dr_update_strobe <= 1'b1;
    hold();
    dr_update_strobe <= 1'b0;
    hold();
  endtask : update
  // Update pass that watches both write clocks cycle by cycle
  task automatic update_watch();
    int lows;
    lows = 0;
    dr_update_strobe <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      if (i == 3) dr_update_strobe <= 1'b0;
      if (ramWrClk_q === 1'b0) lows++;
      check("fallClk", fallWrClk, !ramWrClk_q);
    end
    check("lowCyc", lows, `RINIT_SETUP_CYC);
  endtask : update_watch
  task automatic load(input logic [7:0] w);
    shift_word(w, 1'b1);
    update();
  endtask : load
  task automatic set_ir(input logic [7:0] v);
    user_instruction_value <= v;
    hold();
    hold();
  endtask : set_ir
  task automatic wait_writes(input int n);
    for (int i = 0; i < 400 && rinit_ram_model_i.nWrites < n; i++) @(posedge ref_clk);
    hold();
  endtask : wait_writes
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    check("wrEn", ramWrEn_q, 0);
    check("wrClk", ramWrClk_q, 1);
    check("fallClk0", fallWrClk, 0);
    check("ready", loadReady_q, 1);
  endtask : t_reset
  task automatic t_basic();
    set_ir(OPC);
    base = rinit_ram_model_i.nWrites;
    shift_word(8'ha5, 1'b1);
    update_watch();
    shift_word(8'hff, 1'b0);
    update();
    load(8'h3c);
    wait_writes(base + 3);
    check("nWr", rinit_ram_model_i.nWrites, base + 3);
    check("m00", rinit_ram_model_i.mem[0][0], 8'ha5);
    check("m01", rinit_ram_model_i.mem[0][1], 8'ha5);
    check("m02", rinit_ram_model_i.mem[0][2], 8'h3c);
    check("addr", ramAddr_q, 3);
  endtask : t_basic
  task automatic t_fill_ring();
    set_ir(8'h00);
    base = rinit_ram_model_i.nWrites;
    // Unmatched words are drained and dropped, so the buffer never fills
    for (int i = 0; i < 16; i++) load(8'h40 + 8'(i));
    check("idle", rinit_ram_model_i.nWrites, base);
    check("drop", loadReady_q, 1);
    set_ir(OPC);
    hold();
    check("noReplay", rinit_ram_model_i.nWrites, base);
    for (int i = 0; i < 16; i++) load(8'h40 + 8'(i));
    wait_writes(base + 16);
    check("nWr16", rinit_ram_model_i.nWrites, base + 16);
    for (int i = 0; i < 16; i++) check("fill", rinit_ram_model_i.mem[0][i], 8'h40 + i);
    check("empty", loadReady_q, 1);
    load(8'hc3);
    wait_writes(base + 17);
    check("m10", rinit_ram_model_i.mem[1][0], 8'hc3);
    check("blk1", rinit_ram_model_i.lastBlk, 1);
    set_ir(8'h00);
    set_ir(OPC);
    load(8'h1e);
    wait_writes(base + 18);
    check("rst0", rinit_ram_model_i.mem[0][0], 8'h1e);
    check("blk0", rinit_ram_model_i.lastBlk, 0);
  endtask : t_fill_ring
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    hold();
    t_reset();
    t_basic();
    t_fill_ring();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    report_and_stop();
  end
endmodule : testbench
